//--- hdl/rcs_pkg.sv
// Constants and types for the reset and clock sequencer.
// Assumes one input clock at 50 MHz that is the main input clock itself.
package rcs_pkg;

  // Internal reset stretch, in main input clock cycles
  localparam int         STRETCH_CYCLES = 512;
  localparam logic [9:0] STRETCH_LAST   = 10'(STRETCH_CYCLES - 1);
  localparam logic [9:0] STRETCH_FULL   = 10'(STRETCH_CYCLES);

  // Divider ratios as log2 of the divide factor
  localparam logic [1:0] LOG2_DIV1 = 2'h0;
  localparam logic [1:0] LOG2_DIV2 = 2'h1;
  localparam logic [1:0] LOG2_DIV8 = 2'h3;

  // Register byte addresses
  localparam logic [3:0] CTRL_ADR = 4'h0;
  localparam logic [3:0] STAT_ADR = 4'h4;

  // Control fields and reset values
  localparam int   CTRL_SRC_BIT = 0;
  localparam int   CTRL_PLL_BIT = 1;
  localparam logic SRC_RESET    = 1'h0;
  localparam logic PLL_RESET    = 1'h0;

  // Status fields
  localparam int STAT_PHASE_LSB  = 0;
  localparam int STAT_PIN_BIT    = 2;
  localparam int STAT_BOOT_LSB   = 3;
  localparam int STAT_ENDIAN_BIT = 5;
  localparam int STAT_MODE_BIT   = 6;
  localparam int STAT_BYP_BIT    = 7;

  // Strap positions on the host data pins
  localparam int HD_ENDIAN_BIT = 8;
  localparam int HD_BOOT_LSB   = 3;

  typedef enum logic [1:0] {
    PH_ASSERT  = 2'b00,
    PH_STRETCH = 2'b01,
    PH_RUN     = 2'b10
  } rcs_phase_t;

endpackage

//--- hdl/rcs_sync.sv
// Two-stage synchroniser for levels that arrive from pins.
// Assumes the destination clock is the main input clock.
`timescale 1ns/1ns
module rcs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

//--- hdl/rcs_clkdiv.sv
// Clock divider giving an enable pulse and a square wave.
// Assumes ratio changes are rare; the first period after a change may be short.
`timescale 1ns/1ns
module rcs_clkdiv
  import rcs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] ratio_log2_i,
  output logic            en_o,
  output logic            wave_o
);

  logic [2:0] cnt_q;
  wire  [2:0] mask   = 3'((4'h1 << ratio_log2_i) - 4'h1);
  wire  [2:0] top    = mask & ~(mask >> 1);
  wire        tick   = (cnt_q & mask) == mask;
  wire        wave_d = |(cnt_q & top);

  // Divide by one gives a steady enable and a flat wave
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 3'h0;
      en_o   <= 1'b0;
      wave_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 3'h1;
      en_o   <= tick;
      wave_o <= wave_d;
    end
  end

endmodule

//--- hdl/rcs_top.sv
// Reset and clock sequencer: stretches the reset pin, latches straps,
// sets clock ratios per reset phase and gates the pin groups.
// Assumes CLOCK_I is the main input clock; pins arrive asynchronously.
//
// How it works
// - Memory clock output follows the synced memory clock input only while select is one after reset.
// - Internal reset is held exactly 512 input cycles after the synced pin rise.
// - All pin groups turn valid when internal reset releases.
// - Boot and endian straps latch from host data 4:3 and 8 at pin rise.
// - With the pin asserted every internal clock runs at input over eight.
// - During the stretch every internal clock stays at input over eight.
// - After reset processor at full rate, peripheral and memory source halved.
// - Memory source appears on memory clock output while select is zero.
// - Third clock output runs at input over eight after reset.
// - PLL stays bypassed until software enables it.
// - Memory bus pins and hold acknowledge float during reset.
// - Memory bus request is marked invalid during reset.
// - Serial port pins and timer outputs float during reset.
// - Remaining host and general purpose pins float during reset.
// - Memory clock output goes low in reset, or floats on one variant.
// - Second clock output is invalid in reset, or floats on one variant.
// - Third clock output is driven low during reset.
// - The three clock outputs are valid within six processor periods.
`timescale 1ns/1ns
module rcs_top
  import rcs_pkg::*;
#(
  parameter bit TRISTATE_VARIANT = 1'b0
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CLOCK_MODE_STRAP_I,
  input  wire logic [15:0] HOST_DATA_PINS_I,
  input  wire logic        MEMORY_CLOCK_INPUT_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        WE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  output logic             INT_RST_N_O,
  output logic             PROCESSOR_CLOCK_EN_O,
  output logic             PERIPHERAL_CLOCK_EN_O,
  output logic             MEM_IF_CLOCK_SOURCE_EN_O,
  output logic             MEMORY_CLOCK_OUTPUT_O,
  output logic             MEMORY_CLOCK_OUTPUT_OE_O,
  output logic             SECOND_CLOCK_OUTPUT_O,
  output logic             SECOND_CLOCK_OUTPUT_OE_O,
  output logic             THIRD_CLOCK_OUTPUT_O,
  output logic             MEM_BUS_OE_O,
  output logic             MEMORY_BUS_REQUEST_VALID_O,
  output logic             SERIAL_TIMER_OE_O,
  output logic             HOST_GPIO_OE_O,
  output logic             PLL_BYPASS_O,
  output logic [1:0]       BOOT_MODE_O,
  output logic             ENDIAN_O,
  output logic             CLOCK_MODE_O
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int SYNC_W = 6;

  logic [SYNC_W-1:0] pins_s;
  logic              pin_prev_q;

  rcs_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .d_i   ({MEMORY_CLOCK_INPUT_I,
             CLOCK_MODE_STRAP_I,
             HOST_DATA_PINS_I[HD_ENDIAN_BIT],
             HOST_DATA_PINS_I[HD_BOOT_LSB+1:HD_BOOT_LSB],
             RESET_N_I}),
    .q_o   (pins_s)
  );

  wire       pin_high  = pins_s[0];
  wire [1:0] boot_s    = pins_s[2:1];
  wire       endian_s  = pins_s[3];
  wire       mode_s    = pins_s[4];
  // Memory clock input is only sampled, so its edges land on our clock grid
  wire       eclk_s    = pins_s[SYNC_W-1];
  wire       pin_rise  = pin_high & ~pin_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Reset phase sequencer

  rcs_phase_t ph_q;
  rcs_phase_t ph_d;
  logic [9:0] stretch_cnt_q;
  logic [9:0] stretch_cnt_d;

  wire stretch_done = stretch_cnt_q == STRETCH_LAST;

  always_comb begin
    ph_d = ph_q;
    case (ph_q)
      PH_ASSERT: begin
        if (pin_rise) begin
          ph_d = PH_STRETCH;
        end
      end
      PH_STRETCH: begin
        if (!pin_high) begin
          ph_d = PH_ASSERT;
        end else if (stretch_done) begin
          ph_d = PH_RUN;
        end
      end
      PH_RUN: begin
        if (!pin_high) begin
          ph_d = PH_ASSERT;
        end
      end
      default: begin
        ph_d = PH_ASSERT;
      end
    endcase
  end

  wire stretch_stay = (ph_q == PH_STRETCH) && (ph_d == PH_STRETCH);

  // Count only while the stretch goes on; leaving it by any path rearms the count,
  // so a reassertion starts the next stretch from zero
  assign stretch_cnt_d = stretch_stay ? stretch_cnt_q + 10'h1 : 10'h0;

  wire run_d    = ph_d == PH_RUN;
  wire assert_d = ph_d == PH_ASSERT;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ph_q          <= PH_ASSERT;
      stretch_cnt_q <= 10'h0;
      pin_prev_q    <= 1'b0;
    end else begin
      ph_q          <= ph_d;
      stretch_cnt_q <= stretch_cnt_d;
      pin_prev_q    <= pin_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strap capture, aligned with the synced pin rise

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      BOOT_MODE_O  <= 2'h0;
      ENDIAN_O     <= 1'b0;
      CLOCK_MODE_O <= 1'b0;
    end else if (ph_q == PH_ASSERT && pin_rise) begin
      BOOT_MODE_O  <= boot_s;
      ENDIAN_O     <= endian_s;
      CLOCK_MODE_O <= mode_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock dividers

  logic run_q;
  logic proc_wave;
  logic periph_wave;
  logic src_wave;
  logic third_wave;

  wire [1:0] proc_ratio  = run_q ? LOG2_DIV1 : LOG2_DIV8;
  wire [1:0] half_ratio  = run_q ? LOG2_DIV2 : LOG2_DIV8;

  rcs_clkdiv u_proc (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .ratio_log2_i (proc_ratio),
    .en_o         (PROCESSOR_CLOCK_EN_O),
    .wave_o       (proc_wave)
  );

  rcs_clkdiv u_periph (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .ratio_log2_i (half_ratio),
    .en_o         (PERIPHERAL_CLOCK_EN_O),
    .wave_o       (periph_wave)
  );

  rcs_clkdiv u_src (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .ratio_log2_i (half_ratio),
    .en_o         (MEM_IF_CLOCK_SOURCE_EN_O),
    .wave_o       (src_wave)
  );

  rcs_clkdiv u_third (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .ratio_log2_i (LOG2_DIV8),
    .en_o         (),
    .wave_o       (third_wave)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control register and pin outputs

  logic src_sel_q;
  logic pll_en_q;

  // Select one passes the synced memory clock input through once running
  wire mem_clk_d = (src_sel_q && run_q) ? eclk_s : src_wave;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q                      <= 1'b0;
      INT_RST_N_O                <= 1'b0;
      MEM_BUS_OE_O               <= 1'b0;
      MEMORY_BUS_REQUEST_VALID_O <= 1'b0;
      SERIAL_TIMER_OE_O          <= 1'b0;
      HOST_GPIO_OE_O             <= 1'b0;
      MEMORY_CLOCK_OUTPUT_O      <= 1'b0;
      MEMORY_CLOCK_OUTPUT_OE_O   <= ~TRISTATE_VARIANT;
      SECOND_CLOCK_OUTPUT_O      <= 1'b0;
      SECOND_CLOCK_OUTPUT_OE_O   <= ~TRISTATE_VARIANT;
      THIRD_CLOCK_OUTPUT_O       <= 1'b0;
      PLL_BYPASS_O               <= 1'b1;
    end else begin
      run_q                      <= run_d;
      INT_RST_N_O                <= run_d;
      MEM_BUS_OE_O               <= run_d;
      MEMORY_BUS_REQUEST_VALID_O <= run_d;
      SERIAL_TIMER_OE_O          <= run_d;
      HOST_GPIO_OE_O             <= run_d;
      MEMORY_CLOCK_OUTPUT_O      <= assert_d ? 1'b0 : mem_clk_d;
      MEMORY_CLOCK_OUTPUT_OE_O   <= ~(assert_d & TRISTATE_VARIANT);
      SECOND_CLOCK_OUTPUT_O      <= assert_d ? 1'b0 : periph_wave;
      SECOND_CLOCK_OUTPUT_OE_O   <= ~(assert_d & TRISTATE_VARIANT);
      THIRD_CLOCK_OUTPUT_O       <= assert_d ? 1'b0 : third_wave;
      PLL_BYPASS_O               <= ~(run_d & pll_en_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state, unmapped reads return zero

  wire req      = CYC_I & STB_I & ~ACK_O;
  wire hit_ctrl = ADR_I == CTRL_ADR;
  wire hit_stat = ADR_I == STAT_ADR;
  // Writes land at the edge where the master sees ack, when the cycle completes
  wire wr_ctrl  = CYC_I & STB_I & ACK_O & WE_I & hit_ctrl & SEL_I[0] & run_q;

  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    if (hit_ctrl) begin
      rd_data[CTRL_SRC_BIT] = src_sel_q;
      rd_data[CTRL_PLL_BIT] = pll_en_q;
    end else if (hit_stat) begin
      rd_data[STAT_PHASE_LSB+1:STAT_PHASE_LSB] = ph_q;
      rd_data[STAT_PIN_BIT]                    = pin_high;
      rd_data[STAT_BOOT_LSB+1:STAT_BOOT_LSB]   = BOOT_MODE_O;
      rd_data[STAT_ENDIAN_BIT]                 = ENDIAN_O;
      rd_data[STAT_MODE_BIT]                   = CLOCK_MODE_O;
      rd_data[STAT_BYP_BIT]                    = PLL_BYPASS_O;
    end
  end

  // Pin reset returns control to defaults; writes only land while running
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_O     <= 1'b0;
      DAT_O     <= 32'h0;
      src_sel_q <= SRC_RESET;
      pll_en_q  <= PLL_RESET;
    end else begin
      ACK_O <= req;
      DAT_O <= (req & ~WE_I) ? rd_data : 32'h0;
      if (ph_q == PH_ASSERT) begin
        src_sel_q <= SRC_RESET;
        pll_en_q  <= PLL_RESET;
      end else if (wr_ctrl) begin
        src_sel_q <= DAT_I[CTRL_SRC_BIT];
        pll_en_q  <= DAT_I[CTRL_PLL_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  localparam int VALID_MAX = 48;

  logic [9:0] stretch_len_q;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      stretch_len_q <= 10'h0;
    end else begin
      stretch_len_q <= (ph_q == PH_STRETCH) ? stretch_len_q + 10'h1 : 10'h0;
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  stretch_len_a : assert property ($rose(INT_RST_N_O) |-> stretch_len_q == STRETCH_FULL)
    else $error("internal reset stretch is not 512 cycles");

  groups_valid_a : assert property ($rose(INT_RST_N_O) |-> MEM_BUS_OE_O
      && SERIAL_TIMER_OE_O && HOST_GPIO_OE_O && MEMORY_BUS_REQUEST_VALID_O)
    else $error("pin groups not valid with internal reset release");

  strap_cap_a : assert property (ph_q == PH_ASSERT && pin_rise
      |=> BOOT_MODE_O == $past(boot_s) && ENDIAN_O == $past(endian_s))
    else $error("straps not captured at pin rise");

  // First pulse after leaving run may still be at full rate, so that cycle is skipped
  proc_slow_a : assert property (ph_q == PH_ASSERT && $past(ph_q) == PH_ASSERT
      && PROCESSOR_CLOCK_EN_O ##1 ph_q == PH_ASSERT |-> !PROCESSOR_CLOCK_EN_O [*7])
    else $error("processor clock not divided by eight in reset");

  proc_full_a : assert property (run_q && $past(run_q, 2) |-> PROCESSOR_CLOCK_EN_O)
    else $error("processor clock not at full rate after reset");

  third_low_a : assert property (ph_q == PH_ASSERT |-> !THIRD_CLOCK_OUTPUT_O
      && !MEMORY_CLOCK_OUTPUT_O && !SECOND_CLOCK_OUTPUT_O)
    else $error("clock outputs not low in reset");

  clocks_valid_a : assert property ($rose(ph_q == PH_STRETCH)
      |-> ##[1:VALID_MAX] $changed(THIRD_CLOCK_OUTPUT_O))
    else $error("third clock output not valid within six periods");

  restart_a : assert property (ph_q != PH_ASSERT ##1 ph_q == PH_ASSERT
      |-> stretch_cnt_q == 10'h0 && !INT_RST_N_O)
    else $error("stretch count not restarted on reassertion");

  bypass_a : assert property ($rose(INT_RST_N_O) |-> PLL_BYPASS_O)
    else $error("PLL not bypassed on reset exit");

endmodule

//--- sim/rcs_board_model.sv
// Board side: reset source, strap pins and the memory clock input.
// Assumes the bench sets reset_req_i and strap_i right after a rising edge.
`timescale 1ns/1ns
module rcs_board_model (
  input  wire logic        clk_i,
  input  wire logic        reset_req_i,
  input  wire logic [16:0] strap_i,
  output logic             reset_n_o,
  output logic             mode_o,
  output logic [15:0]      host_o,
  output logic             mem_clk_o
);
  int hold_q = 0;
  initial begin
    reset_n_o = 1'b0;
    {mode_o, host_o} = 17'h00000;
    mem_clk_o = 1'b0;
    // Offset keeps its edges off the main clock's rising edges
    #3;
    // Free running, reset included, unrelated to the main clock
    forever #30 mem_clk_o = ~mem_clk_o;
  end
  always @(posedge clk_i) begin
    reset_n_o <= ~reset_req_i;
    hold_q <= reset_req_i ? 0 : (hold_q < 8 ? hold_q + 1 : hold_q);
    // Straps released after their hold: pins then show the inverse
    {mode_o, host_o} <= (reset_req_i || hold_q < 5) ? strap_i : ~strap_i;
  end
endmodule

//--- sim/tb.sv
// Bench for the reset and clock sequencer: strap rows, then restart and bus cases.
// Assumes the board model drives the reset pin, straps and memory clock input.
`timescale 1ns/1ns
module tb;
  import rcs_pkg::*;
  typedef struct {logic [16:0] strap; logic [1:0] boot; logic endian;} rcs_row_t;
  // Three edges of board model and sync, one to enter stretch, one as the bench reads before updates land
  localparam int STRETCH_SEEN = STRETCH_CYCLES + 5;
  logic        clk = 1'b0, rst = 1'b1, reset_req = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [16:0] strap = 17'h00000;
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [15:0] host;
  logic        pin_n, mode_pin, mem_clk, ack, irn, pe, pp, pm, mco, mcoe, sco, scoe, tco;
  logic        mbo, brv, sto, hgo, byp, endn, mode;
  logic [1:0]  boot;
  int          n_errors = 0, comparisons = 0, n_cyc;
  int          c_pe, c_pp, c_pm, r_mco, r_sco, r_tco, h_tco;
  rcs_row_t    rows [4] = '{'{17'h0FEE7, 2'h0, 1'b0}, '{17'h10108, 2'h1, 1'b1},
                            '{17'h00010, 2'h2, 1'b0}, '{17'h1FEFF, 2'h3, 1'b0}};

  initial forever #10 clk = ~clk;

  rcs_board_model board_u (.clk_i(clk), .reset_req_i(reset_req), .strap_i(strap),
    .reset_n_o(pin_n), .mode_o(mode_pin), .host_o(host), .mem_clk_o(mem_clk));

  rcs_top dut_u (.CLOCK_I(clk), .RST_I(rst), .RESET_N_I(pin_n), .CLOCK_MODE_STRAP_I(mode_pin),
    .HOST_DATA_PINS_I(host), .MEMORY_CLOCK_INPUT_I(mem_clk), .ADR_I(adr), .DAT_I(wdat),
    .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack),
    .INT_RST_N_O(irn), .PROCESSOR_CLOCK_EN_O(pe), .PERIPHERAL_CLOCK_EN_O(pp),
    .MEM_IF_CLOCK_SOURCE_EN_O(pm), .MEMORY_CLOCK_OUTPUT_O(mco), .MEMORY_CLOCK_OUTPUT_OE_O(mcoe),
    .SECOND_CLOCK_OUTPUT_O(sco), .SECOND_CLOCK_OUTPUT_OE_O(scoe), .THIRD_CLOCK_OUTPUT_O(tco),
    .MEM_BUS_OE_O(mbo), .MEMORY_BUS_REQUEST_VALID_O(brv), .SERIAL_TIMER_OE_O(sto),
    .HOST_GPIO_OE_O(hgo), .PLL_BYPASS_O(byp), .BOOT_MODE_O(boot), .ENDIAN_O(endn),
    .CLOCK_MODE_O(mode));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Values are read at the edge, before the design's updates land
  task automatic measure(input int len);
    logic m0, s0, t0;
    {c_pe, c_pp, c_pm, r_mco, r_sco, r_tco, h_tco} = '0;
    m0 = mco;
    s0 = sco;
    t0 = tco;
    repeat (len) begin
      @(posedge clk);
      n_cyc++;
      c_pe += pe;
      c_pp += pp;
      c_pm += pm;
      h_tco += tco;
      r_mco += mco & ~m0;
      r_sco += sco & ~s0;
      r_tco += tco & ~t0;
      m0 = mco;
      s0 = sco;
      t0 = tco;
    end
  endtask

  task automatic wait_run();
    while (irn !== 1'b1 && n_cyc < 2000) begin
      @(posedge clk);
      n_cyc++;
    end
  endtask

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk(n < 20, "bus cycle never acknowledged");
    @(posedge clk);
  endtask

  task automatic chk_assert();
    measure(16);
    chk(c_pe == 2 && c_pp == 2 && c_pm == 2, "enables in reset");
    chk({irn, mbo, brv, sto, hgo} === 5'h00, "groups active in reset");
    chk({mco, mcoe} === 2'b01, "memory clock output in reset");
    chk({sco, scoe} === 2'b01, "second clock output in reset");
    chk(tco === 1'b0 && r_tco == 0, "third clock output in reset");
    chk(byp === 1'b1, "bypass in reset");
  endtask

  task automatic release_run();
    reset_req <= 1'b0;
    n_cyc = 0;
    measure(48);
    chk(r_mco > 3 && r_sco > 3 && r_tco > 3, "clock outputs late");
    measure(16);
    chk(c_pe == 2 && c_pp == 2 && c_pm == 2 && irn === 1'b0, "stretch enables");
    chk(r_mco == 2 && r_sco == 2 && r_tco == 2, "stretch clock outputs");
    wait_run();
    chk(n_cyc == STRETCH_SEEN, "stretch length");
    chk({mbo, brv, sto, hgo} === 4'hF, "groups at release");
    measure(8);
    measure(16);
    chk(c_pe == 16 && c_pp == 8 && c_pm == 8, "run enables");
    chk(r_mco == 8 && r_sco == 8, "run memory and second clock");
    chk(r_tco == 2 && h_tco == 8, "third clock rate");
    chk(byp === 1'b1, "bypass after reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      reset_req <= 1'b1;
      strap <= rows[i].strap;
      repeat (8) @(posedge clk);
      chk_assert();
      release_run();
      chk({boot, endn, mode} === {rows[i].boot, rows[i].endian, rows[i].strap[16]}, "straps");
      $display("strap row %0d done", i);
    end
    // Reassert mid-stretch: count must start again
    reset_req <= 1'b1;
    repeat (8) @(posedge clk);
    reset_req <= 1'b0;
    repeat (200) @(posedge clk);
    reset_req <= 1'b1;
    repeat (6) @(posedge clk);
    release_run();
    $display("restart test done");
    wb(STAT_ADR, 1'b0, 32'h0);
    chk(rd === 32'h000000DE, "status word");
    wb(CTRL_ADR, 1'b1, 32'h2);
    wb(CTRL_ADR, 1'b0, 32'h0);
    chk(rd === 32'h00000002 && byp === 1'b0, "pll enable");
    wb(CTRL_ADR, 1'b1, 32'h1);
    measure(8);
    measure(16);
    chk(r_mco > 3 && r_mco < 7, "memory clock input not passed out");
    wb(4'h8, 1'b1, 32'hFFFFFFFF);
    wb(4'h8, 1'b0, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    $display("bus test done");
    // Low wins over a running memory clock input
    reset_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk_assert();
    reset_req <= 1'b0;
    n_cyc = 0;
    repeat (20) @(posedge clk);
    wb(CTRL_ADR, 1'b1, 32'h3);
    wait_run();
    chk(irn === 1'b1, "no release after reassertion");
    wb(CTRL_ADR, 1'b0, 32'h0);
    chk(rd === 32'h0 && byp === 1'b1, "control written in stretch");
    $display("refusal test done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
